// *** hdl/pmd_pkg.sv ***
// Operation
// - classification turns sense current into a class, readable in event and status
// - auto mode repeats detection until valid, then classifies and powers
// - in auto mode the class never blocks or alters power-on
// - strap high at power-up starts all ports in auto, low leaves host control
// - host may override the operating mode by register at any time
// - semi-auto detects and classifies continuously, updates registers, never powers itself
// - manual mode runs each requested function once per command, no autonomous moves
// - power-off mode stays unpowered, idle, and clears status and enable bits
// - a powered port below minimum load loses power and goes idle; auto mode returns it to detection
// - dc timer counts below 7.5 mA; timeout shuts port and sets fault flag
// - dc timer clears only after current stays above threshold 17% of dropout
// - after clearing, a new undercurrent restarts the count from zero
// - timeout length comes from a field of timing register 0x16
// - ac mode injects 110 Hz; high impedance runs timer; timeout shuts, flags
// - ac timer clears whenever impedance falls below the threshold
// - ac current is reported as dc equivalent of rectified probe current
// - two-wire interface is slave only, fast mode, at most 400 kHz
// - slave never holds the serial clock low
// - slave address is 20h plus a four-bit hardware setting
package pmd_pkg;
  localparam int NPORT = 4;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES_DFLT = TICK_US * CLK_MHZ;
  localparam int DROPOUT_MS = 300;
  localparam int RECOVER_PCT = 17;
  localparam logic [7:0] RECOVER_TICKS =
    8'((DROPOUT_MS * RECOVER_PCT * 10 + TICK_US - 1) / TICK_US);
  localparam int UNLOAD_MS0 = 75;
  localparam int UNLOAD_MS1 = 150;
  localparam int UNLOAD_MS2 = 300;
  localparam int UNLOAD_MS3 = 600;
  localparam logic [9:0] UNLOAD_T0 = 10'(UNLOAD_MS0 * 1000 / TICK_US);
  localparam logic [9:0] UNLOAD_T1 = 10'(UNLOAD_MS1 * 1000 / TICK_US);
  localparam logic [9:0] UNLOAD_T2 = 10'(UNLOAD_MS2 * 1000 / TICK_US);
  localparam logic [9:0] UNLOAD_T3 = 10'(UNLOAD_MS3 * 1000 / TICK_US);
  localparam logic [6:0] SLAVE_BASE = 7'h20;
  localparam logic [7:0] REG_EVT = 8'h04;
  localparam logic [7:0] REG_FLT = 8'h06;
  localparam logic [7:0] REG_PSTAT = 8'h0c;
  localparam logic [7:0] REG_PWR = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h12;
  localparam logic [7:0] REG_DISEN = 8'h13;
  localparam logic [7:0] REG_DCEN = 8'h14;
  localparam logic [7:0] REG_TCFG = 8'h16;
  localparam logic [7:0] REG_CMD = 8'h19;
  localparam int TCFG_UNLOAD_LSB = 0;

  typedef enum logic [1:0] {M_OFF, M_MAN, M_SEMI, M_AUTO} pmd_mode_e;
  typedef enum logic [1:0] {P_IDLE, P_DET, P_CLS, P_PWR} pmd_port_e;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK} pmd_i2c_e;

  function automatic logic [9:0] unload_limit(input logic [1:0] sel);
    case (sel)
      2'h0: return UNLOAD_T0;
      2'h1: return UNLOAD_T1;
      2'h2: return UNLOAD_T2;
      default: return UNLOAD_T3;
    endcase
  endfunction : unload_limit
endpackage : pmd_pkg

// *** hdl/pmd_sync.sv ***
`timescale 1ns/1ps
module pmd_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pmd_sync_s;
  pmd_sync_s r, n;
  always_comb begin
    n.s1 = d_i;
    n.s2 = r.s1;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) r <= '0;
    else r <= n;
  end
  assign q_o = r.s2;
endmodule : pmd_sync

// *** hdl/pmd_unload_timer.sv ***
`timescale 1ns/1ps
module pmd_unload_timer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tick_i,
  input wire logic armed_i,
  input wire logic ac_mode_i,
  input wire logic low_i,
  input wire logic [1:0] sel_i,
  output logic timeout_o
);
  import pmd_pkg::*;
  typedef struct packed {
    logic [9:0] cnt;
    logic [7:0] good;
    logic timeout;
  } pmd_tmr_s;
  pmd_tmr_s r, n;
  logic [9:0] lim;
  always_comb begin
    n = r;
    n.timeout = 1'b0;
    lim = unload_limit(sel_i);
    if (!armed_i) begin
      n.cnt = 10'h000;
      n.good = 8'h00;
    end else if (ac_mode_i && !low_i) begin
      n.cnt = 10'h000;
      n.good = 8'h00;
    end else if (tick_i) begin
      if (low_i) begin
        n.good = 8'h00;
        if (r.cnt + 10'h001 >= lim) begin
          n.timeout = 1'b1;
          n.cnt = 10'h000;
        end else begin
          n.cnt = r.cnt + 10'h001;
        end
      end else if (r.good + 8'h01 >= RECOVER_TICKS) begin
        n.cnt = 10'h000;
        n.good = 8'h00;
      end else begin
        n.good = r.good + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) r <= '0;
    else r <= n;
  end
  assign timeout_o = r.timeout;

  ac_clear_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    armed_i && ac_mode_i && !low_i |=> r.cnt == 10'h000)
    else $error("ac timer not cleared");
  expire_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    armed_i && tick_i && low_i && r.cnt + 10'h001 == lim |=> timeout_o ##1 !timeout_o)
    else $error("timeout not signalled once");
  recover_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    armed_i && !ac_mode_i && tick_i && !low_i && r.good + 8'h01 < RECOVER_TICKS
    |=> r.cnt == $past(r.cnt))
    else $error("dc timer cleared early");
endmodule : pmd_unload_timer

// *** hdl/pmd_port_ctrl.sv ***
`timescale 1ns/1ps
module pmd_port_ctrl
  import pmd_pkg::*;
#(
  parameter int TICK_CYCLES = pmd_pkg::TICK_CYCLES_DFLT
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic auto_strap_i,
  input wire logic [3:0] addr_sel_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_input_pin_i,
  output logic serial_data_output_pin_o,
  output logic serial_data_output_pin_oe_o,
  input wire logic [3:0] det_done_i,
  input wire logic [3:0] det_ok_i,
  input wire logic [3:0] cls_done_i,
  input wire logic [11:0] cls_level_i,
  input wire logic [3:0] under_i,
  input wire logic [3:0] hiz_i,
  output logic [3:0] det_run_o,
  output logic [3:0] cls_run_o,
  output logic [3:0] power_en_o,
  output logic [3:0] sine_en_o,
  output logic [3:0] port_unload_fault_flag_o
);
  import pmd_pkg::*;

  typedef struct packed {
    logic [1:0] settle;
    logic strapped;
    logic scl_q;
    logic sda_q;
    pmd_i2c_e ist;
    logic [2:0] bit_cnt;
    logic done;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rw;
    logic first;
    logic nack;
    logic oe;
    logic sdo;
    logic [7:0] ptr;
    logic [16:0] tick_cnt;
    logic tick;
    pmd_mode_e [3:0] mode;
    pmd_port_e [3:0] pst;
    logic [3:0] det_en;
    logic [3:0] cls_en;
    logic [3:0] dc_en;
    logic [3:0] ac_en;
    logic [7:0] tcfg;
    logic [3:0] det_evt;
    logic [3:0] cls_evt;
    logic [3:0] flt;
    logic [3:0] det_ok;
    logic [3:0] pwr;
    logic [3:0][2:0] cls;
    logic [3:0] det_q;
    logic [3:0] cls_q;
    logic [3:0] det_run;
    logic [3:0] cls_run;
    logic [3:0] sine;
  } pmd_top_s;

  function automatic logic [7:0] rd_reg(input pmd_top_s s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      REG_EVT: v = {s.cls_evt, s.det_evt};
      REG_FLT: v = {4'h0, s.flt};
      REG_PWR: v = {4'h0, s.pwr};
      REG_MODE: v = s.mode;
      REG_DISEN: v = {s.ac_en, s.dc_en};
      REG_DCEN: v = {s.cls_en, s.det_en};
      REG_TCFG: v = s.tcfg;
      default: begin
        for (int p = 0; p < NPORT; p++) begin
          if (a == REG_PSTAT + 8'(p)) begin
            v = {s.pwr[p], s.cls[p], 3'h0, s.det_ok[p]};
          end
        end
      end
    endcase
    return v;
  endfunction : rd_reg

  pmd_top_s r, n;
  logic [38:0] sy;
  logic [11:0] cls_lv;
  logic [3:0] hiz_s;
  logic [3:0] under_s;
  logic [3:0] cls_s;
  logic [3:0] ok_s;
  logic [3:0] det_s;
  logic sda_s;
  logic scl_s;
  logic [3:0] addr_s;
  logic auto_s;
  logic [3:0] to;
  logic wr;
  logic [7:0] wa;
  logic [7:0] wd;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [3:0] cmd_on;
  logic [3:0] cmd_off;
  logic [3:0] det_rise;
  logic [3:0] cls_rise;

  pmd_sync #(
    .W(39)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i({auto_strap_i, addr_sel_i, serial_clock_i, serial_data_input_pin_i,
          det_done_i, det_ok_i, cls_done_i, under_i, hiz_i, cls_level_i}),
    .q_o(sy)
  );
  assign cls_lv = sy[11:0];
  assign hiz_s = sy[15:12];
  assign under_s = sy[19:16];
  assign cls_s = sy[23:20];
  assign ok_s = sy[27:24];
  assign det_s = sy[31:28];
  assign sda_s = sy[32];
  assign scl_s = sy[33];
  assign addr_s = sy[37:34];
  assign auto_s = sy[38];

  for (genvar p = 0; p < NPORT; p++) begin : g_tmr
    pmd_unload_timer u_tmr (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(r.tick),
      .armed_i(r.pwr[p] & (r.dc_en[p] | r.ac_en[p])),
      .ac_mode_i(r.ac_en[p]),
      .low_i(r.ac_en[p] ? hiz_s[p] : under_s[p]),
      .sel_i(r.tcfg[TCFG_UNLOAD_LSB +: 2]),
      .timeout_o(to[p])
    );
  end

  always_comb begin
    n = r;
    wr = 1'b0;
    wa = r.ptr;
    wd = r.sh;
    cmd_on = 4'h0;
    cmd_off = 4'h0;
    det_rise = det_s & ~r.det_q;
    cls_rise = cls_s & ~r.cls_q;
    n.det_q = det_s;
    n.cls_q = cls_s;
    n.sdo = 1'b0;
    // strap taken once the synchroniser has settled
    if (!r.strapped) begin
      if (r.settle == 2'h3) begin
        n.strapped = 1'b1;
        for (int p = 0; p < NPORT; p++) begin
          n.mode[p] = auto_s ? M_AUTO : M_MAN;
        end
        if (auto_s) begin
          n.det_en = 4'hf;
          n.cls_en = 4'hf;
          n.dc_en = 4'hf;
        end
      end else begin
        n.settle = r.settle + 2'h1;
      end
    end
    n.tick = r.tick_cnt == 17'(TICK_CYCLES - 1);
    n.tick_cnt = n.tick ? 17'h00000 : r.tick_cnt + 17'h00001;

    n.scl_q = scl_s;
    n.sda_q = sda_s;
    rise = scl_s & ~r.scl_q;
    fall = ~scl_s & r.scl_q;
    start = scl_s & r.scl_q & r.sda_q & ~sda_s;
    stop = scl_s & r.scl_q & ~r.sda_q & sda_s;
    if (stop) begin
      n.ist = I_IDLE;
      n.oe = 1'b0;
      n.ptr = 8'h00;
    end else if (start) begin
      n.ist = I_ADDR;
      n.bit_cnt = 3'h0;
      n.done = 1'b0;
      n.oe = 1'b0;
      n.first = 1'b1;
    end else begin
      case (r.ist)
        I_ADDR, I_WR: begin
          if (rise) begin
            n.sh = {r.sh[6:0], sda_s};
            n.bit_cnt = r.bit_cnt + 3'h1;
            n.done = r.bit_cnt == 3'h7;
          end else if (fall && r.done) begin
            n.done = 1'b0;
            n.bit_cnt = 3'h0;
            if (r.ist == I_ADDR) begin
              if (r.sh[7:1] == SLAVE_BASE + {3'h0, addr_s}) begin
                n.oe = 1'b1;
                n.rw = r.sh[0];
                n.ist = I_AACK;
              end else begin
                n.ist = I_IDLE;
              end
            end else begin
              n.oe = 1'b1;
              n.ist = I_WACK;
              if (r.first) begin
                n.ptr = r.sh;
                n.first = 1'b0;
              end else begin
                wr = 1'b1;
                n.ptr = r.ptr + 8'h01;
              end
            end
          end
        end
        I_AACK, I_RACK: begin
          if (rise) begin
            // own bits seen on the input
            n.nack = sda_s & (r.ist == I_RACK);
          end else if (fall) begin
            n.bit_cnt = 3'h0;
            if (r.ist == I_RACK && r.nack) begin
              n.oe = 1'b0;
              n.ist = I_IDLE;
            end else if (r.ist == I_RACK || r.rw) begin
              n.tx = rd_reg(r, r.ptr);
              n.oe = ~n.tx[7];
              n.ist = I_RD;
            end else begin
              n.oe = 1'b0;
              n.ist = I_WR;
            end
          end
        end
        I_WACK: begin
          if (fall) begin
            n.oe = 1'b0;
            n.ist = I_WR;
          end
        end
        I_RD: begin
          // data changes only after the master's falling edge
          if (fall) begin
            if (r.bit_cnt == 3'h7) begin
              n.oe = 1'b0;
              n.ist = I_RACK;
              n.ptr = r.ptr + 8'h01;
            end else begin
              n.tx = {r.tx[6:0], 1'b0};
              n.oe = ~r.tx[6];
              n.bit_cnt = r.bit_cnt + 3'h1;
            end
          end
        end
        default: n.ist = I_IDLE;
      endcase
    end

    // host writes land before hardware sets so a set wins
    if (wr) begin
      case (wa)
        REG_EVT: begin
          n.det_evt = r.det_evt & ~wd[3:0];
          n.cls_evt = r.cls_evt & ~wd[7:4];
        end
        REG_FLT: n.flt = r.flt & ~wd[3:0];
        REG_MODE: begin
          for (int p = 0; p < NPORT; p++) begin
            n.mode[p] = pmd_mode_e'(wd[2*p +: 2]);
          end
        end
        REG_DISEN: begin
          n.dc_en = wd[3:0];
          n.ac_en = wd[7:4];
        end
        REG_DCEN: begin
          n.det_en = wd[3:0];
          n.cls_en = wd[7:4];
        end
        REG_TCFG: n.tcfg = wd;
        REG_CMD: begin
          cmd_on = wd[3:0];
          cmd_off = wd[7:4];
        end
        default: ;
      endcase
    end

    for (int p = 0; p < NPORT; p++) begin
      case (r.pst[p])
        P_IDLE: begin
          if (r.mode[p] == M_AUTO || (r.mode[p] != M_OFF && r.det_en[p])) begin
            n.pst[p] = P_DET;
          end else if (r.mode[p] == M_MAN && r.cls_en[p]) begin
            n.pst[p] = P_CLS;
          end
        end
        P_DET: begin
          if (det_rise[p]) begin
            n.det_evt[p] = 1'b1;
            n.det_ok[p] = ok_s[p];
            if (r.mode[p] == M_MAN) begin
              n.det_en[p] = 1'b0;
              n.pst[p] = P_IDLE;
            end else if (ok_s[p] && (r.mode[p] == M_AUTO || r.cls_en[p])) begin
              n.pst[p] = P_CLS;
            end else begin
              n.pst[p] = P_IDLE;
            end
          end
        end
        P_CLS: begin
          if (cls_rise[p]) begin
            n.cls[p] = cls_lv[3*p +: 3];
            n.cls_evt[p] = 1'b1;
            n.pst[p] = (r.mode[p] == M_AUTO) ? P_PWR : P_IDLE;
            if (r.mode[p] == M_MAN) begin
              n.cls_en[p] = 1'b0;
            end
          end
        end
        P_PWR: begin
          if (to[p]) begin
            n.flt[p] = 1'b1;
            n.pst[p] = P_IDLE;
          end
        end
        default: n.pst[p] = P_IDLE;
      endcase
      if (cmd_off[p]) begin
        n.pst[p] = P_IDLE;
      end else if (cmd_on[p] && r.mode[p] != M_OFF) begin
        n.pst[p] = P_PWR;
      end
      if (n.mode[p] == M_OFF) begin
        n.pst[p] = P_IDLE;
        n.det_en[p] = 1'b0;
        n.cls_en[p] = 1'b0;
        n.dc_en[p] = 1'b0;
        n.ac_en[p] = 1'b0;
        n.det_evt[p] = 1'b0;
        n.cls_evt[p] = 1'b0;
        n.det_ok[p] = 1'b0;
        n.flt[p] = 1'b0;
        n.cls[p] = 3'h0;
      end
      n.pwr[p] = n.pst[p] == P_PWR;
      n.det_run[p] = n.pst[p] == P_DET;
      n.cls_run[p] = n.pst[p] == P_CLS;
      n.sine[p] = n.pwr[p] & n.ac_en[p];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) r <= '0;
    else r <= n;
  end

  assign serial_data_output_pin_o = r.sdo;
  assign serial_data_output_pin_oe_o = r.oe;
  assign det_run_o = r.det_run;
  assign cls_run_o = r.cls_run;
  assign power_en_o = r.pwr;
  assign sine_en_o = r.sine;
  assign port_unload_fault_flag_o = r.flt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  strap_auto_a: assert property (
    !r.strapped && r.settle == 2'h3 && auto_s
    |=> r.mode[0] == M_AUTO && r.mode[3] == M_AUTO && r.dc_en == 4'hf)
    else $error("strap did not select auto");
  mode_write_a: assert property (
    wr && wa == REG_MODE && r.strapped |=> r.mode == $past(wd))
    else $error("mode write lost");
  addr_ack_a: assert property (
    r.ist == I_ADDR && fall && r.done && r.sh[7:1] == SLAVE_BASE + {3'h0, addr_s}
    |=> serial_data_output_pin_oe_o && r.ist == I_AACK)
    else $error("own address not acknowledged");

  for (genvar p = 0; p < NPORT; p++) begin : g_chk
    auto_detect_a: assert property (
      r.mode[p] == M_AUTO && r.pst[p] == P_IDLE && !wr |=> det_run_o[p])
      else $error("auto port did not detect");
    auto_power_a: assert property (
      r.mode[p] == M_AUTO && r.pst[p] == P_CLS && cls_rise[p] && !wr
      |=> power_en_o[p] && r.cls[p] == $past(cls_lv[3*p +: 3]))
      else $error("auto port did not power");
    semi_hold_a: assert property (
      r.mode[p] == M_SEMI && r.pst[p] != P_PWR && !wr |=> !power_en_o[p])
      else $error("semi port powered itself");
    manual_once_a: assert property (
      r.mode[p] == M_MAN && r.pst[p] == P_DET && det_rise[p] && !wr
      |=> !r.det_en[p] ##1 !det_run_o[p])
      else $error("manual detection repeated");
    off_clear_a: assert property (
      r.strapped && r.mode[p] == M_OFF && !wr
      |=> !power_en_o[p] && !r.det_en[p] && !port_unload_fault_flag_o[p])
      else $error("off port not cleared");
    unload_off_a: assert property (
      r.pst[p] == P_PWR && to[p] && r.mode[p] == M_AUTO && !wr
      |=> !power_en_o[p] && port_unload_fault_flag_o[p] ##1 det_run_o[p])
      else $error("unload did not drop port");
    flag_wins_a: assert property (
      r.pst[p] == P_PWR && to[p] && r.mode[p] != M_OFF && wr && wa == REG_FLT
      |=> port_unload_fault_flag_o[p])
      else $error("fault set lost to clear");
  end
endmodule : pmd_port_ctrl

// *** verif/pmd_pd_model.sv ***
`timescale 1ns/1ps
module pmd_pd_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic slow_i,
  input wire logic [3:0] valid_i,
  input wire logic [11:0] cls_i,
  input wire logic [3:0] unload_i,
  input wire logic [3:0] hiz_i,
  input wire logic [3:0] det_run_i,
  input wire logic [3:0] cls_run_i,
  input wire logic [3:0] power_en_i,
  output logic [3:0] det_done_o,
  output logic [3:0] det_ok_o,
  output logic [3:0] cls_done_o,
  output logic [11:0] cls_level_o,
  output logic [3:0] under_o,
  output logic [3:0] hiz_o
);
  logic [3:0][7:0] cnt;
  logic [7:0] dly;
  assign dly = slow_i ? 8'hc8 : 8'h14;
  // an unpowered port draws no current
  assign under_o = unload_i | ~power_en_i;
  assign hiz_o = hiz_i | ~power_en_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        cnt[p] <= (det_run_i[p] | cls_run_i[p]) && cnt[p] != dly ? cnt[p] + 8'h1 : 8'h0;
      end
    end
  end
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      det_done_o[p] = det_run_i[p] && cnt[p] == dly;
      cls_done_o[p] = cls_run_i[p] && cnt[p] == dly;
      // signature and class are meaningless outside their phase
      det_ok_o[p] = valid_i[p] ^ ~det_run_i[p];
      cls_level_o[3*p +: 3] = cls_i[3*p +: 3] ^ {3{~cls_run_i[p]}};
    end
  end
endmodule : pmd_pd_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  import pmd_pkg::*;
  logic clk_i = 0, rst_b_i = 0, scl = 1, sda_m = 1, slow = 0, strap = 1, oe, sdo;
  logic [3:0] sel = 0, valid = 0, unload = 0, hiz = 0;
  logic [3:0] dd, dok, cd, und, hz, drun, crun, pwr, sine, flt;
  logic [11:0] cls = 0, lvl;
  logic [8:0] q;
  logic [7:0] r;
  int miscompares = 0, checked = 0;
  wire sda = sda_m & (sdo | ~oe);
  always #5 clk_i = ~clk_i;
  pmd_port_ctrl #(.TICK_CYCLES(10)) u_pmd_port_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .auto_strap_i(strap), .addr_sel_i(sel), .serial_clock_i(scl),
    .serial_data_input_pin_i(sda), .serial_data_output_pin_o(sdo),
    .serial_data_output_pin_oe_o(oe), .det_done_i(dd), .det_ok_i(dok), .cls_done_i(cd),
    .cls_level_i(lvl), .under_i(und), .hiz_i(hz), .det_run_o(drun), .cls_run_o(crun),
    .power_en_o(pwr), .sine_en_o(sine), .port_unload_fault_flag_o(flt));
  pmd_pd_model u_pmd_pd_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
    .valid_i(valid), .cls_i(cls), .unload_i(unload), .hiz_i(hiz), .det_run_i(drun),
    .cls_run_i(crun), .power_en_i(pwr), .det_done_o(dd), .det_ok_o(dok), .cls_done_o(cd),
    .cls_level_o(lvl), .under_o(und), .hiz_o(hz));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // bit period 2.52 us, below 400 kHz
  task hb;
    repeat (63) @(negedge clk_i);
  endtask : hb
  task ticks(input int n);
    repeat (n * 10) @(negedge clk_i);
  endtask : ticks
  task xb(input logic [8:0] d);
    for (int i = 8; i >= 0; i--) begin
      sda_m = d[i];
      hb;
      scl = 1;
      hb;
      q[i] = sda;
      hb;
      scl = 0;
      hb;
    end
  endtask : xb
  task st;
    sda_m = 1;
    hb;
    scl = 1;
    hb;
    sda_m = 0;
    hb;
    scl = 0;
    hb;
  endtask : st
  task sp;
    sda_m = 0;
    hb;
    scl = 1;
    hb;
    sda_m = 1;
    hb;
  endtask : sp
  task wr(input logic [7:0] off, input logic [23:0] d, input int n);
    st;
    xb({SLAVE_BASE + 7'(sel), 2'b01});
    chk("address ack", 8'h0, {7'h0, q[0]});
    xb({off, 1'b1});
    for (int i = n - 1; i >= 0; i--) begin
      xb({d[8*i +: 8], 1'b1});
    end
    sp;
  endtask : wr
  task rd(input logic [7:0] off);
    st;
    xb({SLAVE_BASE + 7'(sel), 2'b01});
    xb({off, 1'b1});
    st;
    xb({SLAVE_BASE + 7'(sel), 2'b11});
    xb(9'h1ff);
    r = q[8:1];
    sp;
  endtask : rd
  task wp(input logic [3:0] m, input logic [3:0] e);
    int n;
    for (n = 0; n < 20000 && (pwr & m) !== e; n++) @(negedge clk_i);
    if (n == 20000) begin
      miscompares++;
      $display("ERROR power wait expected %h seen %h", e, pwr & m);
      final_report;
    end
  endtask : wp
  initial begin
    sel = 4'($urandom(58));
    cls = 12'($urandom);
    slow = 1'($urandom);
    valid = 4'he;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1;
    wp(4'he, 4'he);
    ticks(50);
    chk("invalid port", 8'h0, {6'h0, pwr[0], crun[0]});
    valid = 4'hf;
    wp(4'hf, 4'hf);
    $display("test auto done");
    rd(REG_PSTAT + 8'h1);
    chk("port status", {1'b1, cls[5:3], 4'h1}, r);
    st;
    xb({SLAVE_BASE + 7'(sel ^ 4'h1), 2'b01});
    sp;
    chk("foreign address", 8'h1, {7'h0, q[0]});
    $display("test register read done");
    wr(REG_TCFG, 24'h1, 1);
    unload = 4'h2;
    ticks(100);
    unload = 0;
    ticks(60);
    unload = 4'h2;
    ticks(140);
    chk("dc early", 8'h2, {4'h0, pwr & 4'h2});
    valid = 4'hd;
    ticks(20);
    chk("dc fault", 8'h2, {4'h0, flt});
    chk("dc power", 8'hd, {4'h0, pwr});
    valid = 4'hf;
    unload = 0;
    wp(4'hf, 4'hf);
    $display("test dc disconnect done");
    wr(REG_DISEN, 24'hf0, 1);
    chk("sine", 8'hf, {4'h0, sine});
    hiz = 4'h4;
    ticks(100);
    hiz = 0;
    ticks(2);
    hiz = 4'h4;
    ticks(140);
    chk("ac early", 8'h2, {4'h0, flt});
    valid = 4'hb;
    ticks(20);
    chk("ac fault", 8'h6, {4'h0, flt});
    chk("ac power", 8'hb, {4'h0, pwr});
    $display("test ac disconnect done");
    wr(REG_MODE, 24'h0, 1);
    wp(4'hf, 4'h0);
    chk("off detect", 8'h0, {4'h0, drun});
    rd(REG_FLT);
    chk("off faults", 8'h0, r);
    valid = 4'hf;
    hiz = 0;
    wr(REG_MODE, 24'haa00ff, 3);
    rd(REG_EVT);
    chk("semi events", 8'hff, r);
    chk("semi power", 8'h0, {4'h0, pwr});
    $display("test modes done");
    // strap low after a mid-run reset leaves ports to the host
    strap = 0;
    rst_b_i = 0;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1;
    ticks(1);
    chk("strap low idle", 8'h0, {pwr, drun});
    wr(REG_DCEN, 24'h1, 1);
    chk("manual once", 8'h0, {4'h0, drun});
    wr(REG_CMD, 24'h2, 1);
    chk("manual power", 8'h2, {4'h0, pwr});
    // auto by host comes with its enables
    wr(REG_MODE, 24'hff0fff, 3);
    wp(4'hf, 4'hf);
    chk("host auto", 8'hf, {4'h0, pwr});
    $display("test strap low done");
    final_report;
  end
endmodule : tb
